// [shared/gptcc_pkg.sv]
// constants, types and register map of the general-purpose timer
package gptcc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [15:0] OFS_CNT = 16'h4500;
    localparam logic [15:0] OFS_CAPA = 16'h4502;
    localparam logic [15:0] OFS_CAPB = 16'h4504;
    localparam logic [15:0] OFS_TOP = 16'h4506;
    localparam logic [15:0] OFS_CMPA = 16'h4508;
    localparam logic [15:0] OFS_CMPB = 16'h450A;
    localparam logic [15:0] OFS_CFG = 16'h450C;
    localparam logic [15:0] OFS_WCFGA = 16'h450E;
    localparam logic [15:0] OFS_WCFGB = 16'h4510;
    localparam logic [15:0] OFS_CCFGA = 16'h4512;
    localparam logic [15:0] OFS_CCFGB = 16'h4514;
    localparam logic [15:0] OFS_IRQ_PEND = 16'h4516;
    localparam logic [15:0] OFS_IRQ_MASK = 16'h4518;
    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int CFG_EXTEN = 12;
    localparam int CFG_EN = 11;
    localparam int CFG_BIDIR = 10;
    localparam int CFG_DOWN = 9;
    localparam int CFG_ONESHOT = 8;
    localparam int CFG_PSCL_LSB = 4;
    localparam int CFG_FILT = 3;
    localparam int CFG_EDGE = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int WCFG_EN = 15;
    localparam int WCFG_INV = 4;
    localparam int WCFG_MODE_LSB = 0;
    localparam int CCFG_FILT = 8;
    localparam int CCFG_MODE_LSB = 5;
    localparam logic [15:0] CFG_WMASK = 16'h1FFF;
    localparam logic [15:0] WCFG_WMASK = 16'h801F;
    localparam logic [15:0] CCFG_WMASK = 16'h0160;
    localparam logic [15:0] TOP_RST = 16'hFFFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [3:0] PSCL_MAX = 4'hA;
    localparam int PSCL_W = 10;
    localparam int FILT_W = 4;
    // ---------------------------------------------------------------
    // interrupt sources
    // ---------------------------------------------------------------
    localparam int IRQ_W = 7;
    localparam int IRQ_WRAP = 0;
    localparam int IRQ_CMPA = 1;
    localparam int IRQ_CMPB = 2;
    localparam int IRQ_ZERO = 3;
    localparam int IRQ_TOP = 4;
    localparam int IRQ_CAPA = 5;
    localparam int IRQ_CAPB = 6;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CAP_OFF = 2'h0, CAP_RISE = 2'h1, CAP_FALL = 2'h2, CAP_BOTH = 2'h3
    } gptcc_cap_mode_t;
    typedef enum logic [1:0] {
        SRC_RC = 2'h0, SRC_32K = 2'h1, SRC_MAIN = 2'h2, SRC_GPIO = 2'h3
    } gptcc_src_t;
    typedef enum logic [3:0] {
        WM_HOLD = 4'h0, WM_TOG_TOP = 4'h1, WM_TOP_A = 4'h2, WM_TOP_B = 4'h3,
        WM_HIGH = 4'h4, WM_A_TOP = 4'h5, WM_TOG_A = 4'h6, WM_A_B = 4'h7,
        WM_LOW = 4'h8, WM_B_TOP = 4'h9, WM_B_A = 4'hA, WM_TOG_B = 4'hB,
        WM_TOG_Z = 4'hC, WM_Z_TOP = 4'hD, WM_Z_A = 4'hE, WM_Z_B = 4'hF
    } gptcc_wave_mode_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } gptcc_bus_t;
endpackage

// [rtl/gptcc_timer.sv]
// general-purpose 16-bit timer with compare outputs and input capture
//
// How it works
// - two compare waveform outputs, A and B
// - capture registers latch count on trigger
// - trigger synchronised, optionally filtered, edge detected
// - edge mode off/rise/fall/both, filter bit
// - filter is four-stage shift register
// - overflow source on up-count wrap
// - sources on reaching compare A, B
// - sources on reaching zero and threshold
// - source for each capture event
// - irq needs local and top-level mask
// - bit 12 makes gate pin stop counting
// - bit 11 enables; other bits locked then
// - bit 10 alternates direction at range ends
// - bit 3 filters the timer clock source, except the main clock
// - count readable live, writable anytime
// - threshold read-write, resets to all ones
// - compare config bit 4 inverts output
// - compare config bits 3:0 pick mode
// - sixteen hold/toggle/set/clear/force modes
// - up to threshold, down to zero
// - repeats, or single pass when one-shot and bit 10 clear
// - clock source is rc/32k/main/gpio
module gptcc_timer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire gptcc_pkg::gptcc_bus_t i_bus,
    output logic [15:0] o_rdata,
    input wire logic i_clk_rc,
    input wire logic i_clk_32k,
    input wire logic i_clk_gpio,
    input wire logic i_ext_gate_pin,
    input wire logic i_capture_trig_a,
    input wire logic i_capture_trig_b,
    input wire logic i_top_irq_en,
    output logic o_wave_out_a,
    output logic o_wave_oe_a,
    output logic o_wave_out_b,
    output logic o_wave_oe_b,
    output logic o_irq
);
    import gptcc_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] top;
        logic [15:0] cmpa;
        logic [15:0] cmpb;
        logic [15:0] cfg;
        logic [1:0][15:0] wcfg;
        logic [1:0][15:0] ccfg;
        logic [1:0][15:0] cap;
        logic [15:0] rdata;
        logic [IRQ_W-1:0] pend;
        logic [IRQ_W-1:0] mask;
        logic dir;
        logic done;
        logic en_prev;
        logic [1:0] wave;
        logic [FILT_W-1:0] ck_filt;
        logic ck_lvl;
        logic [PSCL_W-1:0] pres;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0][FILT_W-1:0] cf;
        logic [1:0] cap_lvl;
    } gptcc_state_t;

    gptcc_state_t s_q;
    gptcc_state_t s_d;

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic logic gptcc_sc(input logic cur, input logic st, input logic cl);
        gptcc_sc = st ? 1'b1 : (cl ? 1'b0 : cur);
    endfunction

    function automatic logic gptcc_wave(input logic [3:0] m, input logic cur,
                                        input logic t, input logic a, input logic b,
                                        input logic z);
        case (gptcc_wave_mode_t'(m))
            WM_HOLD: gptcc_wave = cur;
            WM_TOG_TOP: gptcc_wave = cur ^ t;
            WM_TOP_A: gptcc_wave = gptcc_sc(cur, t, a);
            WM_TOP_B: gptcc_wave = gptcc_sc(cur, t, b);
            WM_HIGH: gptcc_wave = 1'b1;
            WM_A_TOP: gptcc_wave = gptcc_sc(cur, a, t);
            WM_TOG_A: gptcc_wave = cur ^ a;
            WM_A_B: gptcc_wave = gptcc_sc(cur, a, b);
            WM_LOW: gptcc_wave = 1'b0;
            WM_B_TOP: gptcc_wave = gptcc_sc(cur, b, t);
            WM_B_A: gptcc_wave = gptcc_sc(cur, b, a);
            WM_TOG_B: gptcc_wave = cur ^ b;
            WM_TOG_Z: gptcc_wave = cur ^ z;
            WM_Z_TOP: gptcc_wave = gptcc_sc(cur, z, t);
            WM_Z_A: gptcc_wave = gptcc_sc(cur, z, a);
            default: gptcc_wave = gptcc_sc(cur, z, b);
        endcase
    endfunction

    function automatic logic gptcc_edge(input logic [1:0] m, input logic prev,
                                        input logic cur);
        case (gptcc_cap_mode_t'(m))
            CAP_RISE: gptcc_edge = !prev && cur;
            CAP_FALL: gptcc_edge = prev && !cur;
            CAP_BOTH: gptcc_edge = prev != cur;
            default: gptcc_edge = 1'b0;
        endcase
    endfunction

    // a filtered level moves only once all stages agree
    function automatic logic gptcc_filt(input logic [FILT_W-1:0] sh, input logic cur);
        if (&sh) begin
            gptcc_filt = 1'b1;
        end else if (~|sh) begin
            gptcc_filt = 1'b0;
        end else begin
            gptcc_filt = cur;
        end
    endfunction

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    logic src_raw;
    logic src_lvl;
    logic src_edge;
    logic tick;
    logic run;
    logic step;
    logic [3:0] psc;
    logic [PSCL_W-1:0] pmask;
    logic [15:0] nxt;
    logic wrap_ev;
    logic ev_top;
    logic ev_a;
    logic ev_b;
    logic ev_z;
    logic [1:0] cap_hit;
    logic [1:0] cin;
    logic [IRQ_W-1:0] set_ev;
    logic [IRQ_W-1:0] clr_ev;
    logic wsel;

    always_comb begin
        s_d = s_q;
        // timer clock source, filter, edge, prescale
        case (gptcc_src_t'(s_q.cfg[CFG_CLK_LSB +: 2]))
            SRC_RC: src_raw = i_clk_rc;
            SRC_32K: src_raw = i_clk_32k;
            SRC_MAIN: src_raw = ~s_q.ck_lvl;
            default: src_raw = i_clk_gpio;
        endcase
        s_d.ck_filt = {s_q.ck_filt[FILT_W-2:0], src_raw};
        src_lvl = src_raw;
        if (s_q.cfg[CFG_FILT] && gptcc_src_t'(s_q.cfg[CFG_CLK_LSB +: 2]) != SRC_MAIN) begin
            src_lvl = gptcc_filt(s_q.ck_filt, s_q.ck_lvl);
        end
        s_d.ck_lvl = src_lvl;
        if (gptcc_src_t'(s_q.cfg[CFG_CLK_LSB +: 2]) == SRC_MAIN) begin
            src_edge = 1'b1;
        end else if (s_q.cfg[CFG_EDGE]) begin
            src_edge = s_q.ck_lvl && !src_lvl;
        end else begin
            src_edge = !s_q.ck_lvl && src_lvl;
        end
        psc = (s_q.cfg[CFG_PSCL_LSB +: 4] > PSCL_MAX) ? PSCL_MAX
                                                      : s_q.cfg[CFG_PSCL_LSB +: 4];
        pmask = PSCL_W'(({{(PSCL_W){1'b0}}, 1'b1} << psc) - 1'b1);
        tick = src_edge && ((s_q.pres & pmask) == pmask);
        if (src_edge) begin
            s_d.pres = s_q.pres + 1'b1;
        end
        // counting
        run = s_q.cfg[CFG_EN] && !s_q.done
            && (!s_q.cfg[CFG_EXTEN] || i_ext_gate_pin);
        step = tick && run;
        nxt = s_q.cnt;
        wrap_ev = 1'b0;
        s_d.en_prev = s_q.cfg[CFG_EN];
        if (s_q.cfg[CFG_EN] && !s_q.en_prev) begin
            s_d.dir = s_q.cfg[CFG_DOWN];
            s_d.done = 1'b0;
        end else if (!s_q.cfg[CFG_EN]) begin
            s_d.done = 1'b0;
        end else if (step && !s_q.dir) begin
            if (s_q.cnt == s_q.top) begin
                if (s_q.cfg[CFG_BIDIR]) begin
                    s_d.dir = 1'b1;
                    nxt = s_q.cnt - ONE16;
                end else if (s_q.cfg[CFG_ONESHOT]) begin
                    s_d.done = 1'b1;
                end else begin
                    nxt = ZERO16;
                    wrap_ev = s_q.cnt == CNT_MAX;
                end
            end else begin
                nxt = s_q.cnt + ONE16;
                wrap_ev = s_q.cnt == CNT_MAX;
            end
        end else if (step) begin
            if (s_q.cnt == ZERO16) begin
                if (s_q.cfg[CFG_BIDIR]) begin
                    s_d.dir = 1'b0;
                    nxt = ONE16;
                end else if (s_q.cfg[CFG_ONESHOT]) begin
                    s_d.done = 1'b1;
                end else begin
                    nxt = s_q.top;
                end
            end else begin
                nxt = s_q.cnt - ONE16;
            end
        end
        s_d.cnt = nxt;
        // compare events fire when the count arrives at a value
        ev_top = step && !s_d.done && nxt == s_q.top;
        ev_z = step && !s_d.done && nxt == ZERO16;
        ev_a = step && !s_d.done && nxt == s_q.cmpa;
        ev_b = step && !s_d.done && nxt == s_q.cmpb;
        for (int i = 0; i < 2; i++) begin
            s_d.wave[i] = gptcc_wave(s_q.wcfg[i][WCFG_MODE_LSB +: 4], s_q.wave[i],
                                     ev_top, ev_a, ev_b, ev_z);
        end
        // capture channels
        cin = {i_capture_trig_b, i_capture_trig_a};
        s_d.sync1 = cin;
        s_d.sync2 = s_q.sync1;
        for (int i = 0; i < 2; i++) begin
            s_d.cf[i] = {s_q.cf[i][FILT_W-2:0], s_q.sync2[i]};
            if (s_q.ccfg[i][CCFG_FILT]) begin
                s_d.cap_lvl[i] = gptcc_filt(s_q.cf[i], s_q.cap_lvl[i]);
            end else begin
                s_d.cap_lvl[i] = s_q.sync2[i];
            end
            cap_hit[i] = gptcc_edge(s_q.ccfg[i][CCFG_MODE_LSB +: 2], s_q.cap_lvl[i],
                                    s_d.cap_lvl[i]);
            if (cap_hit[i]) begin
                s_d.cap[i] = s_q.cnt;
            end
        end
        // interrupt sources, set wins over clear
        set_ev = '0;
        set_ev[IRQ_WRAP] = wrap_ev;
        set_ev[IRQ_CMPA] = ev_a;
        set_ev[IRQ_CMPB] = ev_b;
        set_ev[IRQ_ZERO] = ev_z;
        set_ev[IRQ_TOP] = ev_top;
        set_ev[IRQ_CAPA] = cap_hit[0];
        set_ev[IRQ_CAPB] = cap_hit[1];
        clr_ev = '0;
        wsel = 1'b0;
        // register writes
        if (i_bus.wr) begin
            if (i_bus.addr == OFS_CNT) begin
                s_d.cnt = i_bus.wdata;
            end else if (i_bus.addr == OFS_TOP) begin
                s_d.top = i_bus.wdata;
            end else if (i_bus.addr == OFS_CMPA) begin
                s_d.cmpa = i_bus.wdata;
            end else if (i_bus.addr == OFS_CMPB) begin
                s_d.cmpb = i_bus.wdata;
            end else if (i_bus.addr == OFS_CFG) begin
                if (s_q.cfg[CFG_EN]) begin
                    s_d.cfg[CFG_EN] = i_bus.wdata[CFG_EN];
                end else begin
                    s_d.cfg = i_bus.wdata & CFG_WMASK;
                end
            end else if (i_bus.addr == OFS_WCFGA || i_bus.addr == OFS_WCFGB) begin
                wsel = i_bus.addr == OFS_WCFGB;
                s_d.wcfg[wsel] = i_bus.wdata & WCFG_WMASK;
            end else if (i_bus.addr == OFS_CCFGA || i_bus.addr == OFS_CCFGB) begin
                wsel = i_bus.addr == OFS_CCFGB;
                s_d.ccfg[wsel] = i_bus.wdata & CCFG_WMASK;
            end else if (i_bus.addr == OFS_IRQ_PEND) begin
                clr_ev = i_bus.wdata[IRQ_W-1:0];
            end else if (i_bus.addr == OFS_IRQ_MASK) begin
                s_d.mask = i_bus.wdata[IRQ_W-1:0];
            end
        end
        s_d.pend = (s_q.pend & ~clr_ev) | set_ev;
        // register reads, data in the following cycle
        s_d.rdata = ZERO16;
        if (i_bus.rd) begin
            if (i_bus.addr == OFS_CNT) begin
                s_d.rdata = s_q.cnt;
            end else if (i_bus.addr == OFS_CAPA) begin
                s_d.rdata = s_q.cap[0];
            end else if (i_bus.addr == OFS_CAPB) begin
                s_d.rdata = s_q.cap[1];
            end else if (i_bus.addr == OFS_TOP) begin
                s_d.rdata = s_q.top;
            end else if (i_bus.addr == OFS_CMPA) begin
                s_d.rdata = s_q.cmpa;
            end else if (i_bus.addr == OFS_CMPB) begin
                s_d.rdata = s_q.cmpb;
            end else if (i_bus.addr == OFS_CFG) begin
                s_d.rdata = s_q.cfg;
            end else if (i_bus.addr == OFS_WCFGA) begin
                s_d.rdata = s_q.wcfg[0];
            end else if (i_bus.addr == OFS_WCFGB) begin
                s_d.rdata = s_q.wcfg[1];
            end else if (i_bus.addr == OFS_CCFGA) begin
                s_d.rdata = s_q.ccfg[0];
            end else if (i_bus.addr == OFS_CCFGB) begin
                s_d.rdata = s_q.ccfg[1];
            end else if (i_bus.addr == OFS_IRQ_PEND) begin
                s_d.rdata = {{(16-IRQ_W){1'b0}}, s_q.pend};
            end else if (i_bus.addr == OFS_IRQ_MASK) begin
                s_d.rdata = {{(16-IRQ_W){1'b0}}, s_q.mask};
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.top <= TOP_RST;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_rdata = s_q.rdata;
    assign o_wave_out_a = s_q.wave[0] ^ s_q.wcfg[0][WCFG_INV];
    assign o_wave_out_b = s_q.wave[1] ^ s_q.wcfg[1][WCFG_INV];
    assign o_wave_oe_a = s_q.wcfg[0][WCFG_EN];
    assign o_wave_oe_b = s_q.wcfg[1][WCFG_EN];
    assign o_irq = i_top_irq_en && |(s_q.pend & s_q.mask);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking gptcc_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_cnt_write: assert property (i_ce && i_bus.wr && i_bus.addr == OFS_CNT
        |=> s_q.cnt == $past(i_bus.wdata))
        else $error("count write not taken");
    chk_cfg_locked: assert property (i_ce && i_bus.wr && i_bus.addr == OFS_CFG
        && s_q.cfg[CFG_EN] && i_bus.wdata[CFG_EN] |=> $stable(s_q.cfg))
        else $error("config changed while enabled");
    chk_gate_hold: assert property (i_ce && s_q.cfg[CFG_EN] && s_q.cfg[CFG_EXTEN]
        && !i_ext_gate_pin && !i_bus.wr |=> $stable(s_q.cnt))
        else $error("count moved with gate pin low");
    chk_wrap_flag: assert property (i_ce && wrap_ev |=> s_q.pend[IRQ_WRAP])
        else $error("wrap source not raised");
    chk_capture_a: assert property (i_ce && cap_hit[0]
        |=> s_q.cap[0] == $past(s_q.cnt))
        else $error("capture A did not latch count");
    chk_down_step: assert property (i_ce && step && s_q.dir && s_q.cnt != ZERO16
        && s_q.en_prev && !i_bus.wr |=> s_q.cnt == $past(s_q.cnt) - ONE16)
        else $error("down count step wrong");
    chk_irq_gate: assert property (!i_top_irq_en || s_q.mask == '0 |-> !o_irq)
        else $error("irq without both masks");
    chk_force_high: assert property (i_ce && step
        && s_q.wcfg[0][WCFG_MODE_LSB +: 4] == WM_HIGH |=> s_q.wave[0])
        else $error("force-high mode not high");
    chk_top_event: assert property (i_ce && ev_top |=> s_q.pend[IRQ_TOP])
        else $error("threshold source not raised");
    chk_oneshot_stop: assert property (s_q.done && s_q.cfg[CFG_EN] && !i_bus.wr
        |=> $stable(s_q.cnt))
        else $error("one-shot count kept running");

    cov_wrap: cover property (i_ce && wrap_ev);
    cov_capture: cover property (i_ce && cap_hit[1]);
    cov_turn: cover property (i_ce && step && s_q.cfg[CFG_BIDIR] ##1 $changed(s_q.dir));
    cov_oneshot: cover property ($rose(s_q.done));
endmodule

// [verification/gptcc_gpio_model.sv]
// far-side model: gpio capture triggers and external gate pin
module gptcc_gpio_model (
    input wire logic i_clk,
    input wire logic [2:0] i_lvl,
    output logic o_trig_a,
    output logic o_trig_b,
    output logic o_gate
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins change only just after a clock edge, never mid-cycle
    always @(posedge i_clk) begin
        {o_gate, o_trig_b, o_trig_a} <= i_lvl;
    end
endmodule

// [verification/tb_top.sv]
// testbench: registers, counting, capture, waveform and irq scenarios
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gptcc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    gptcc_bus_t bus = '0;
    logic [2:0] lvl = 3'h0;
    logic top_en = 1'b0;
    logic ce = 1'b1;
    logic gclk = 1'b0;
    logic trig_a, trig_b, gate, wa, oea, wb, oeb, irq;
    logic [15:0] rdata, r;
    int error_cnt = 0;
    int samples_checked = 0;
    initial begin
        forever #50 clk = ~clk;
    end
    gptcc_timer dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
        .i_clk_rc(1'b0), .i_clk_32k(1'b0), .i_clk_gpio(gclk), .i_ext_gate_pin(gate),
        .i_capture_trig_a(trig_a), .i_capture_trig_b(trig_b), .i_top_irq_en(top_en),
        .o_wave_out_a(wa), .o_wave_oe_a(oea), .o_wave_out_b(wb), .o_wave_oe_b(oeb),
        .o_irq(irq));
    gptcc_gpio_model gpio (.i_clk(clk), .i_lvl(lvl), .o_trig_a(trig_a), .o_trig_b(trig_b),
        .o_gate(gate));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1 r = rdata;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        op(1'b1, a, d);
    endtask
    task automatic rd(input logic [15:0] a);
        op(1'b0, a, 16'h0000);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pin(input logic [2:0] v);
        @(posedge clk);
        lvl <= v;
        @(posedge clk);
    endtask
    task automatic stop_timer;
        wr(OFS_CFG, 16'h0000);
        wr(OFS_CFG, 16'h0000);
        wr(OFS_IRQ_PEND, 16'h007F);
    endtask
    task automatic wait_pend(input int b);
        int i;
        for (i = 0; i < 200; i++) begin
            rd(OFS_IRQ_PEND);
            if (r[b] === 1'b1) break;
        end
        chk(16'(r[b]), 16'h0001);
        if (i == 200) report_and_stop();
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        rd(OFS_TOP);
        chk(r, 16'hFFFF);
        rd(OFS_CNT);
        chk(r, 16'h0000);
        rd(16'h4520);
        chk(r, 16'h0000);
        wr(OFS_TOP, 16'h0005);
        rd(OFS_TOP);
        chk(r, 16'h0005);
    endtask
    task automatic t_count;
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CFG, 16'h0802);
        wait_pend(IRQ_TOP);
        wait_pend(IRQ_ZERO);
        wr(OFS_CFG, 16'h0402);
        rd(OFS_CFG);
        chk(r, 16'h0002);
        stop_timer();
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CFG, 16'h0902);
        cyc(20);
        rd(OFS_CNT);
        chk(r, 16'h0005);
        stop_timer();
        wr(OFS_CNT, 16'h0003);
        wr(OFS_CFG, 16'h0A02);
        wait_pend(IRQ_ZERO);
        stop_timer();
    endtask
    task automatic t_wrap;
        logic [15:0] c [2] = '{16'h0802, 16'h0C02};
        logic [15:0] e [2] = '{16'h0001, 16'h0000};
        wr(OFS_TOP, 16'hFFFF);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CNT, 16'hFFF8);
            wr(OFS_CFG, c[k]);
            cyc(30);
            rd(OFS_IRQ_PEND);
            chk(16'(r[IRQ_WRAP]), e[k]);
            chk(16'(r[IRQ_TOP]), 16'h0001);
            stop_timer();
        end
    endtask
    task automatic t_gate;
        wr(OFS_TOP, 16'h0105);
        wr(OFS_CNT, 16'h0100);
        wr(OFS_CFG, 16'h1802);
        cyc(20);
        rd(OFS_CNT);
        chk(r, 16'h0100);
        pin(3'b100);
        wait_pend(IRQ_TOP);
        stop_timer();
        pin(3'b000);
    endtask
    task automatic t_capture;
        wr(OFS_CNT, 16'h1234);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CCFGA, 16'(m) << 5);
            wr(OFS_IRQ_PEND, 16'h007F);
            pin(3'b001);
            cyc(4);
            rd(OFS_IRQ_PEND);
            chk(16'(r[IRQ_CAPA]), 16'(m == 1 || m == 3));
            wr(OFS_IRQ_PEND, 16'h007F);
            pin(3'b000);
            cyc(4);
            rd(OFS_IRQ_PEND);
            chk(16'(r[IRQ_CAPA]), 16'(m >= 2));
        end
        rd(OFS_CAPA);
        chk(r, 16'h1234);
        wr(OFS_CCFGB, 16'h0120);
        wr(OFS_IRQ_PEND, 16'h007F);
        pin(3'b010);
        cyc(2);
        rd(OFS_IRQ_PEND);
        chk(16'(r[IRQ_CAPB]), 16'h0000);
        cyc(8);
        rd(OFS_IRQ_PEND);
        chk(16'(r[IRQ_CAPB]), 16'h0001);
        rd(OFS_CAPB);
        chk(r, 16'h1234);
        pin(3'b000);
    endtask
    task automatic t_wave;
        logic [15:0] w [5] = '{16'h8004, 16'h8014, 16'h8008, 16'h8018, 16'h0004};
        logic [4:0] o = 5'b01001;
        logic [4:0] oe = 5'b01111;
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CFG, 16'h0802);
        for (int k = 0; k < 5; k++) begin
            wr(OFS_WCFGA, w[k]);
            cyc(3);
            chk(16'(oea), 16'(oe[k]));
            if (oe[k]) chk(16'(wa), 16'(o[k]));
        end
        wr(OFS_WCFGB, 16'h8004);
        cyc(3);
        chk(16'({oeb, wb}), 16'h0003);
        stop_timer();
    endtask
    task automatic t_irq;
        wr(OFS_TOP, 16'h0005);
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CFG, 16'h0802);
        wait_pend(IRQ_TOP);
        wr(OFS_CFG, 16'h0000);
        @(posedge clk);
        top_en <= 1'b1;
        cyc(1);
        chk(16'(irq), 16'h0000);
        wr(OFS_IRQ_MASK, 16'h0010);
        cyc(1);
        chk(16'(irq), 16'h0001);
        @(posedge clk);
        top_en <= 1'b0;
        cyc(1);
        chk(16'(irq), 16'h0000);
    endtask
    task automatic t_cmp;
        wr(OFS_TOP, 16'h0005);
        wr(OFS_CMPA, 16'h0003);
        wr(OFS_CMPB, 16'h0004);
        wr(OFS_WCFGA, 16'h8007);
        wr(OFS_WCFGB, 16'h800E);
        wr(OFS_CNT, 16'h0000);
        wr(OFS_IRQ_PEND, 16'h007F);
        wr(OFS_CFG, 16'h0902);
        cyc(20);
        rd(OFS_IRQ_PEND);
        chk(16'(r[IRQ_CMPA]), 16'h0001);
        chk(16'(r[IRQ_CMPB]), 16'h0001);
        chk(16'({wb, wa}), 16'h0000);
        rd(OFS_CMPB);
        chk(r, 16'h0004);
        stop_timer();
    endtask
    task automatic gpulse(input int n, input int h);
        repeat (n) begin
            @(posedge clk);
            gclk <= 1'b1;
            repeat (h) @(posedge clk);
            gclk <= 1'b0;
            repeat (h) @(posedge clk);
        end
        cyc(8);
    endtask
    task automatic t_clk;
        wr(OFS_TOP, 16'hFFFF);
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CFG, 16'h0813);
        gpulse(4, 1);
        rd(OFS_CNT);
        chk(r, 16'h0002);
        stop_timer();
        wr(OFS_CNT, 16'h0000);
        wr(OFS_CFG, 16'h081F);
        gpulse(4, 1);
        rd(OFS_CNT);
        chk(r, 16'h0000);
        gpulse(4, 6);
        rd(OFS_CNT);
        chk(r, 16'h0002);
        stop_timer();
    endtask
    task automatic t_ce;
        wr(OFS_CNT, 16'h0042);
        @(posedge clk);
        ce <= 1'b0;
        wr(OFS_CNT, 16'h0077);
        @(posedge clk);
        ce <= 1'b1;
        rd(OFS_CNT);
        chk(r, 16'h0042);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_count();
        t_wrap();
        t_gate();
        t_capture();
        t_wave();
        t_irq();
        t_cmp();
        t_clk();
        t_ce();
        report_and_stop();
    end
endmodule
